/* hw/port_pin_config_consts.vh */
// Purpose: constants for the port pin configuration block
// Assumes: 8-bit register port, 6 port pins
// Notes:   register offsets are local choices
`ifndef PORT_PIN_CONFIG_CONSTS_VH
`define PORT_PIN_CONFIG_CONSTS_VH

`define PPC_ADDR_W          4
`define PPC_OFF_ANALOG      4'h0
`define PPC_OFF_PULLUP      4'h1
`define PPC_OFF_CHGEN       4'h2
`define PPC_OFF_PORT        4'h3
`define PPC_OFF_DIR         4'h4
`define PPC_OFF_CTRL        4'h5
`define PPC_OFF_IRQ_STAT    4'h6
`define PPC_OFF_IRQ_EN      4'h7
`define PPC_OFF_IRQ_CLR     4'h8

`define PPC_ANALOG_RST      8'h0F
`define PPC_ANALOG_MASK     8'h7F
`define PPC_PULLUP_RST      6'h37
`define PPC_PULLUP_MASK     6'h37
`define PPC_CHGEN_RST       6'h00
`define PPC_DIR_RST         6'h3F
`define PPC_CTRL_RST        2'h0

`define PPC_CLKSEL_HI       6
`define PPC_CLKSEL_LO       4
`define PPC_CLK_DIV2        3'h0
`define PPC_CLK_DIV8        3'h1
`define PPC_CLK_DIV32       3'h2
`define PPC_CLK_DIV4        3'h4
`define PPC_CLK_DIV16       3'h5
`define PPC_CLK_DIV64       3'h6
`define PPC_CLK_RC_LOW      2'h3

`define PPC_PIN_THREE       3
`define PPC_XTAL_PINS       6'h30

`define PPC_CTRL_GPULL      0
`define PPC_CTRL_GIRQ       1

`define PPC_EV_CHANGE       0
`define PPC_EV_WIDTH        1

`endif

/* hw/pin_sync.v */
// Purpose: three-stage synchroniser for port pin inputs
// Assumes: pins are asynchronous to clk
// Notes:   a change is accepted once stages two and three agree
`timescale 1ns/1ns
module pin_sync #(
  parameter WIDTH = 6
) (
  // clock and reset
  input  wire             clk,
  input  wire             resetn,
  input  wire             ce,
  // data
  input  wire [WIDTH-1:0] async_in,
  output reg  [WIDTH-1:0] sync_out
);

  reg [WIDTH-1:0] s1_q;
  reg [WIDTH-1:0] s2_q;
  reg [WIDTH-1:0] s3_q;
  integer         i;

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s1_q     <= {WIDTH{1'b0}};
      s2_q     <= {WIDTH{1'b0}};
      s3_q     <= {WIDTH{1'b0}};
      sync_out <= {WIDTH{1'b0}};
    end else if (ce) begin
      s1_q <= async_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
      for (i = 0; i < WIDTH; i = i + 1) begin
        if (s2_q[i] == s3_q[i]) begin
          sync_out[i] <= s3_q[i];
        end
      end
    end
  end

endmodule

/* hw/port_pin_config_control.v */
// Purpose: per-pin analog select, weak pull-up and change-interrupt control for a six-pin port
// Assumes: single clock, register port with read data one cycle after the read strobe
// Notes:   pin electrical drive is modelled as output, output enable and pull-up enable signals
//
// Overview of operation
// - converter clock code decodes to divider or RC
// - analog bits 3-0 map pins 4,2,1,0
// - analog pin kills input, pull-up, change detect
// - pull-up bits 5-4, 2-0 enable pull-ups
// - global pull-up permission also required
// - output direction turns pull-up off
// - pin three pull-up only as master clear
// - crystal mode: pull-up bits 5-4 read one
// - change enable bits arm pins, reset zero
// - change interrupt needs global interrupt enable
// - crystal mode: change enable 5-4 read one
// - unimplemented bits ignore writes, read zero
// - flag set beats simultaneous clear
// - armed mismatches versus last read set flag
// - analog pin digital reads return zero
//
// The strobed register port and the register offsets are this design's own decisions.
`timescale 1ns/1ns
`include "port_pin_config_consts.vh"
module port_pin_config_control #(
  parameter NPINS = 6
) (
  // clock, reset, enable
  input  wire                   clk,
  input  wire                   resetn,
  input  wire                   ce,
  // register port
  input  wire [`PPC_ADDR_W-1:0] addr,
  input  wire [7:0]             wdata,
  input  wire                   wr,
  input  wire                   rd,
  output reg  [7:0]             rdata,
  // device configuration
  input  wire                   master_clear_function_enable,
  input  wire                   xtal_mode,
  // port pins
  input  wire [NPINS-1:0]       pin_in,
  output wire [NPINS-1:0]       pin_out,
  output wire [NPINS-1:0]       pin_oe,
  output wire [NPINS-1:0]       pin_pullup,
  output wire [NPINS-1:0]       pin_analog,
  // converter clock selection
  output reg  [2:0]             conv_div_sel,
  output reg                    conv_use_rc,
  // interrupt
  output wire                   port_change_flag,
  output wire                   irq
);

  reg  [7:0]       analog_select_q;
  reg  [NPINS-1:0] pullup_enable_q;
  reg  [NPINS-1:0] change_irq_enable_q;
  reg  [NPINS-1:0] port_latch_q;
  reg  [NPINS-1:0] pin_direction_q;
  reg  [1:0]       ctrl_q;
  reg  [NPINS-1:0] last_read_q;
  reg              change_flag_q;
  reg  [`PPC_EV_WIDTH-1:0] irq_stat_q;
  reg  [`PPC_EV_WIDTH-1:0] irq_en_q;
  reg  [7:0]       rdata_d;

  wire [NPINS-1:0] pin_sync_q;
  wire [NPINS-1:0] analog_pins;
  wire [NPINS-1:0] digital_in;
  wire [NPINS-1:0] mismatch;
  wire             change_set;
  wire             flag_clear;
  wire             port_rd;
  wire             port_wr;
  wire [5:0]       pullup_view;
  wire [5:0]       chgen_view;

  function is_addr;
    input [`PPC_ADDR_W-1:0] a;
    input [`PPC_ADDR_W-1:0] off;
    begin
      is_addr = (a == off);
    end
  endfunction

  pin_sync #(
    .WIDTH    (NPINS)
  ) u_sync (
    .clk      (clk),
    .resetn   (resetn),
    .ce       (ce),
    .async_in (pin_in),
    .sync_out (pin_sync_q)
  );

  // analog bit order: bit3 pin4, bit2 pin2, bit1 pin1, bit0 pin0
  assign analog_pins = {1'b0, analog_select_q[3], 1'b0,
                        analog_select_q[2], analog_select_q[1], analog_select_q[0]};

  assign digital_in = pin_sync_q & ~analog_pins;

  assign pin_analog = analog_pins;
  assign pin_out    = port_latch_q;
  assign pin_oe     = ~pin_direction_q; // output drive unaffected by analog select

  genvar g;
  generate
    for (g = 0; g < NPINS; g = g + 1) begin : pull_gen
      if (g == `PPC_PIN_THREE) begin : master_clear_function_pull
        assign pin_pullup[g] = master_clear_function_enable;
      end else begin : norm_pull
        assign pin_pullup[g] = pullup_enable_q[g] & ctrl_q[`PPC_CTRL_GPULL]
                               & pin_direction_q[g] & ~analog_pins[g];
      end
    end
  endgenerate

  // converter clock decode
  always @* begin
    conv_use_rc  = (analog_select_q[`PPC_CLKSEL_LO+1:`PPC_CLKSEL_LO] == `PPC_CLK_RC_LOW);
    conv_div_sel = analog_select_q[`PPC_CLKSEL_HI:`PPC_CLKSEL_LO];
  end

  assign port_rd = rd & is_addr(addr, `PPC_OFF_PORT);
  assign port_wr = wr & is_addr(addr, `PPC_OFF_PORT);

  assign mismatch   = (digital_in ^ last_read_q) & change_irq_enable_q & ~analog_pins;
  assign change_set = |mismatch;
  assign flag_clear = wr & is_addr(addr, `PPC_OFF_CTRL) & ~wdata[`PPC_CTRL_GIRQ + 1];

  assign port_change_flag = change_flag_q;
  assign irq = |(irq_stat_q & irq_en_q) & ctrl_q[`PPC_CTRL_GIRQ];

  // pin three has no software pull-up; crystal pins read back as one
  assign pullup_view = (xtal_mode ? (pullup_enable_q | `PPC_XTAL_PINS) : pullup_enable_q)
                       & `PPC_PULLUP_MASK;
  assign chgen_view  = xtal_mode ? (change_irq_enable_q | `PPC_XTAL_PINS)
                                 : change_irq_enable_q;

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      analog_select_q     <= `PPC_ANALOG_RST;
      pullup_enable_q     <= `PPC_PULLUP_RST;
      change_irq_enable_q <= `PPC_CHGEN_RST;
      port_latch_q        <= {NPINS{1'b0}};
      pin_direction_q     <= `PPC_DIR_RST;
      ctrl_q              <= `PPC_CTRL_RST;
      irq_en_q            <= {`PPC_EV_WIDTH{1'b0}};
    end else if (ce && wr) begin
      case (addr)
        `PPC_OFF_ANALOG: analog_select_q     <= wdata & `PPC_ANALOG_MASK;
        `PPC_OFF_PULLUP: pullup_enable_q     <= wdata[5:0] & `PPC_PULLUP_MASK;
        `PPC_OFF_CHGEN:  change_irq_enable_q <= wdata[5:0];
        `PPC_OFF_PORT:   port_latch_q        <= wdata[5:0];
        `PPC_OFF_DIR:    pin_direction_q     <= wdata[5:0];
        `PPC_OFF_CTRL:   ctrl_q              <= wdata[1:0];
        `PPC_OFF_IRQ_EN: irq_en_q            <= wdata[`PPC_EV_WIDTH-1:0];
        default: ;
      endcase
    end
  end

  // last-read latch and change flag; port read or write ends the mismatch
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      last_read_q   <= {NPINS{1'b0}};
      change_flag_q <= 1'b0;
      irq_stat_q    <= {`PPC_EV_WIDTH{1'b0}};
    end else if (ce) begin
      if (port_rd || port_wr) begin
        last_read_q <= digital_in;
      end
      if (change_set) begin
        change_flag_q <= 1'b1;
      end else if (flag_clear) begin
        change_flag_q <= 1'b0;
      end
      if (change_set) begin
        irq_stat_q[`PPC_EV_CHANGE] <= 1'b1;
      end else if (wr && is_addr(addr, `PPC_OFF_IRQ_CLR) && wdata[`PPC_EV_CHANGE]) begin
        irq_stat_q[`PPC_EV_CHANGE] <= 1'b0;
      end
    end
  end

  always @* begin
    case (addr)
      `PPC_OFF_ANALOG:   rdata_d = analog_select_q;
      `PPC_OFF_PULLUP:   rdata_d = {2'h0, pullup_view};
      `PPC_OFF_CHGEN:    rdata_d = {2'h0, chgen_view};
      `PPC_OFF_PORT:     rdata_d = {2'h0, digital_in};
      `PPC_OFF_DIR:      rdata_d = {2'h0, pin_direction_q};
      `PPC_OFF_CTRL:     rdata_d = {5'h00, change_flag_q, ctrl_q};
      `PPC_OFF_IRQ_STAT: rdata_d = {7'h00, irq_stat_q};
      `PPC_OFF_IRQ_EN:   rdata_d = {7'h00, irq_en_q};
      default:           rdata_d = 8'h00;
    endcase
  end

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rdata <= 8'h00;
    end else if (ce) begin
      rdata <= rd ? rdata_d : 8'h00;
    end
  end

endmodule

/* sim/pin_board.sv */
// Purpose: board side of the six port pins
// Assumes: the board drives every pin the block leaves undriven
// Notes:   a driven pin reads back its own output latch
`timescale 1ns/1ns
module pin_board (
  // pin signals
  input  wire [5:0] pin_out,
  input  wire [5:0] pin_oe,
  input  wire [5:0] ext,
  output wire [5:0] pin_in
);
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext);
endmodule

/* sim/port_pin_config_control_asserts.sv */
// Purpose: port-level checks of the pin configuration block
// Assumes: register reads answer one cycle after the strobe
// Notes:   bound into every instance of the block
`timescale 1ns/1ns
module ppc_checker (
  input wire       clk,
  input wire       resetn,
  input wire       ce,
  input wire [3:0] addr,
  input wire [7:0] wdata,
  input wire       wr,
  input wire       rd,
  input wire [7:0] rdata,
  input wire       master_clear_function_enable,
  input wire       xtal_mode,
  input wire [5:0] pin_oe,
  input wire [5:0] pin_pullup,
  input wire [5:0] pin_analog,
  input wire [2:0] conv_div_sel,
  input wire       conv_use_rc
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  a_clk_code_decode: assert property (wr && ce && addr == 4'h0 |=>
    conv_div_sel == $past(wdata[6:4]) && conv_use_rc == (&$past(wdata[5:4]))) else $error("clock select");
  a_analog_pin_map: assert property (wr && ce && addr == 4'h0 |=>
    pin_analog == {1'b0, $past(wdata[3]), 1'b0, $past(wdata[2:0])}) else $error("analog map");
  a_analog_no_pull: assert property ((pin_pullup & pin_analog) == 6'h00) else $error("analog pull");
  a_output_no_pull: assert property ((pin_pullup & pin_oe & 6'h37) == 6'h00) else $error("output pull");
  a_pin3_master_clear_function_pull: assert property (pin_pullup[3] == master_clear_function_enable) else $error("pin3 pull");
  a_xtal_pull_read: assert property (rd && ce && addr == 4'h1 && xtal_mode |=> rdata[5:4] == 2'h3)
    else $error("xtal pull read");
  a_xtal_chg_read: assert property (rd && ce && addr == 4'h2 && xtal_mode |=> rdata[5:4] == 2'h3)
    else $error("xtal change read");
  a_unmapped_read: assert property (rd && ce && addr > 4'h8 |=> rdata == 8'h00) else $error("unmapped");
  a_pull_unimpl: assert property (rd && ce && addr == 4'h1 |=>
    rdata[7:6] == 2'h0 && !rdata[3]) else $error("pull unimpl");
endmodule
bind port_pin_config_control ppc_checker u_ppc_checker (.clk(clk), .resetn(resetn), .ce(ce), .addr(addr),
  .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .master_clear_function_enable(master_clear_function_enable), .xtal_mode(xtal_mode),
  .pin_oe(pin_oe), .pin_pullup(pin_pullup), .pin_analog(pin_analog), .conv_div_sel(conv_div_sel),
  .conv_use_rc(conv_use_rc));

/* sim/port_pin_config_control_tb.sv */
// Purpose: self-checking bench for the pin configuration block
// Assumes: pin 3 strapped as master clear
// Notes:   read results are queued and compared by a monitor
`timescale 1ns/1ns
module port_pin_config_control_tb;
  reg         clk = 0, resetn = 0, ce = 1, wr = 0, rd = 0, master_clear_function_enable = 1, xtal_mode = 0, pend = 0;
  reg  [3:0]  addr = 4'h0;
  reg  [7:0]  wdata = 8'h00, a, d, p, g;
  reg  [5:0]  ext = 6'h00, am;
  wire [7:0]  rdata;
  wire [5:0]  pin_in, pin_out, pin_oe, pin_pullup, pin_analog;
  wire [2:0]  conv_div_sel;
  wire        conv_use_rc, port_change_flag, irq;
  reg  [7:0]  expq[$];
  integer     errors = 0, total_checks = 0, i;
  always #50 clk = ~clk;
  port_pin_config_control u_port_pin_config_control (.clk(clk), .resetn(resetn), .ce(ce), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .master_clear_function_enable(master_clear_function_enable), .xtal_mode(xtal_mode),
    .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .pin_pullup(pin_pullup), .pin_analog(pin_analog),
    .conv_div_sel(conv_div_sel), .conv_use_rc(conv_use_rc), .port_change_flag(port_change_flag), .irq(irq));
  pin_board u_pin_board (.pin_out(pin_out), .pin_oe(pin_oe), .ext(ext), .pin_in(pin_in));
  task chk(input [7:0] gv, input [7:0] ev);
    total_checks++;
    if (gv !== ev) begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, gv, ev);
    end
  endtask
  task wreg(input [3:0] ad, input [7:0] dv);
    @(posedge clk); addr <= ad; wdata <= dv; wr <= 1;
    @(posedge clk); wr <= 0;
  endtask
  task rreg(input [3:0] ad, input [7:0] ev);
    @(posedge clk); addr <= ad; rd <= 1; expq.push_back(ev);
    @(posedge clk); rd <= 0;
  endtask
  task test_done;
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  always @(posedge clk) begin
    if (pend) chk(rdata, expq.pop_front());
    pend <= rd;
  end
  initial begin
    #1000000; errors++; test_done;
  end
  initial begin
    a = $urandom(51);
    repeat (20) @(posedge clk);
    resetn <= 1;
    rreg(4'h0, 8'h0F); rreg(4'h1, 8'h37); rreg(4'h2, 8'h00);
    wreg(4'hB, 8'hFF); wreg(4'h0, 8'hFF); rreg(4'h0, 8'h7F); rreg(4'hB, 8'h00);
    ce <= 0; wreg(4'h2, 8'h3F); ce <= 1; rreg(4'h2, 8'h00);
    $display("test readback done");
    for (i = 0; i < 8; i++) begin
      wreg(4'h0, {1'b0, i[2:0], 4'h0}); @(negedge clk);
      chk({4'h0, conv_use_rc, conv_div_sel}, {4'h0, i[1:0] == 2'h3, i[2:0]});
    end
    for (i = 0; i < 16; i++) begin
      a = $urandom; d = $urandom; p = $urandom; g = $urandom;
      am = {1'b0, a[3], 1'b0, a[2:0]};
      wreg(4'h0, a & 8'h7F); wreg(4'h4, d); wreg(4'h1, p); wreg(4'h5, {7'h0, g[0]}); @(negedge clk);
      chk({2'h0, pin_analog}, {2'h0, am});
      chk({2'h0, pin_oe}, {2'h0, ~d[5:0]});
      chk({2'h0, pin_pullup}, {2'h0, {6{g[0]}} & p[5:0] & 6'h37 & d[5:0] & ~am} | 8'h08);
    end
    $display("test clock analog pullup done");
    wreg(4'h1, 8'h00); wreg(4'h2, 8'h00); xtal_mode <= 1;
    rreg(4'h1, 8'h30); rreg(4'h2, 8'h30); xtal_mode <= 0;
    rreg(4'h1, 8'h00); rreg(4'h2, 8'h00);
    master_clear_function_enable <= 0; @(negedge clk);
    chk({7'h0, pin_pullup[3]}, 8'h00);
    @(posedge clk); master_clear_function_enable <= 1;
    $display("test crystal readback done");
    wreg(4'h0, 8'h00); wreg(4'h4, 8'h3F); wreg(4'h7, 8'h01); wreg(4'h2, 8'h01);
    rreg(4'h3, 8'h00); wreg(4'h5, 8'h02); wreg(4'h8, 8'h01);
    ext <= 6'h01; repeat (6) @(posedge clk); @(negedge clk);
    chk({6'h0, irq, port_change_flag}, 8'h03);
    rreg(4'h6, 8'h01); rreg(4'h3, 8'h01); wreg(4'h5, 8'h02); wreg(4'h8, 8'h01); @(negedge clk);
    chk({6'h0, irq, port_change_flag}, 8'h00);
    ext <= 6'h00; repeat (6) @(posedge clk);
    wreg(4'h5, 8'h02); @(negedge clk);
    chk({7'h0, port_change_flag}, 8'h01);
    wreg(4'h5, 8'h00); @(negedge clk);
    chk({6'h0, irq, port_change_flag}, 8'h01);
    ext <= 6'h01; wreg(4'h0, 8'h01); repeat (4) @(posedge clk);
    rreg(4'h3, 8'h00); wreg(4'h5, 8'h00); wreg(4'h8, 8'h01);
    ext <= 6'h00; repeat (6) @(posedge clk); @(negedge clk);
    chk({7'h0, port_change_flag}, 8'h00);
    wreg(4'h3, 8'h2A); @(negedge clk);
    chk({2'h0, pin_out}, 8'h2A);
    $display("test change interrupt done");
    repeat (3) @(posedge clk);
    test_done;
  end
endmodule
